// file: logic/serial_fmt_consts.vh
`ifndef SERIAL_FMT_CONSTS_VH
`define SERIAL_FMT_CONSTS_VH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_FMT_OPT   8'h00
`define ADDR_EXT_A     8'h04
`define ADDR_SER_FMT   8'h08
`define ADDR_DIV       8'h0c
`define ADDR_TXH       8'h10
`define ADDR_RXH       8'h14
`define ADDR_STAT      8'h18

// ****************************************
// serial_format_options fields
// ****************************************
`define FO_ORDER       3
`define FO_FLIP        2
`define FO_SCMODE      0
`define FO_RSV_ONES    8'hf2
`define FO_RESET       8'hf2

// ****************************************
// serial_extended_mode_a fields
// ****************************************
`define EA_SEL_EN      7
`define EA_RESET       8'h00

// ****************************************
// serial_format_register fields
// ****************************************
`define SF_SYNC        7
`define SF_CHR7        6
`define SF_PEN         5
`define SF_ODD         4
`define SF_RXEN        1
`define SF_TXEN        0
`define SF_RESET       8'h00

// ****************************************
// status fields and misc
// ****************************************
`define ST_TXEMPTY     0
`define ST_RXFULL      1
`define ST_TXBUSY      2
`define ST_PERR        3
`define DIV_RESET      16'h0010
`define LAST_BIT_8     3'h7
`define LAST_BIT_7     3'h6

`endif

// file: logic/tx_bit_shifter.v
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// transmit shift register, lsb leaves first
// ****************************************
module tx_bit_shifter #(
  parameter WIDTH = 8
) (
  input  wire             clock_i,
  input  wire             rstn_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] data_i,
  input  wire             shift_i,
  output wire             bit_o
);

  reg [WIDTH-1:0] shift_reg;

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      shift_reg <= {WIDTH{1'b1}};
    end else if (load_i) begin
      shift_reg <= data_i;
    end else if (shift_i) begin
      shift_reg <= {1'b1, shift_reg[WIDTH-1:1]};
    end
  end

  assign bit_o = shift_reg[0];

endmodule

`default_nettype wire

// file: logic/serial_format_and_select_control.v
// Operation
// [R1] format register bits 7..4 always read as ones, writes ignored
// [R2] format register bit 1 always reads as one
// [R3] bit 3 picks lsb-first (0) or msb-first (1) for transmit and receive
// [R4] bit order obeyed only with eight data bits, else lsb-first
// [R5] bit 2 set inverts transmit data and stores receive data inverted
// [R6] inversion never touches the parity bit; only odd/even flips it
// [R7] bit 0 selects normal (0) or smart card (1) operation
// [R8] software keeps the smart card select at zero on this part
// [R9] extended bit 7 enables the external select function
// [R10] select enabled and pin high: transmit output floats, clock forced high
// [R11] select function acts only in clocked synchronous mode
// [R12] pin back low: normal transmit drive and real clock input return
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_consts.vh"

module serial_format_and_select_control #(
  parameter DIV_W = 16
) (
  input  wire        clock_i,
  input  wire        rstn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        serial_clock_pin_i,
  input  wire        receive_data_in_i,
  input  wire        select_input_pin_i,
  output reg         transmit_data_out_o,
  output reg         transmit_data_oe_o
);

  // ****************************************
  // helpers
  // ****************************************
  function [7:0] reverse8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        reverse8[k] = v[7-k];
      end
    end
  endfunction

  localparam S_IDLE  = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA  = 3'h2;
  localparam S_PAR   = 3'h3;
  localparam S_STOP  = 3'h4;

  // ****************************************
  // registers
  // ****************************************
  reg [7:0]       fmt_opt;
  reg [7:0]       ext_a;
  reg [7:0]       ser_fmt;
  reg [DIV_W-1:0] divisor;
  reg [7:0]       tx_hold;
  reg [7:0]       rx_hold;
  reg             tx_empty;
  reg             rx_full;
  reg             par_err;

  wire apb_access = psel_i && penable_i;
  wire apb_write  = apb_access && pready_o && pwrite_i;
  wire apb_read   = apb_access && pready_o && !pwrite_i;

  wire sync_mode  = ser_fmt[`SF_SYNC];
  wire eight_bits = sync_mode || !ser_fmt[`SF_CHR7];
  wire msb_first  = fmt_opt[`FO_ORDER] && eight_bits;                    // [R3] [R4]
  wire flip       = fmt_opt[`FO_FLIP];
  // smart card stays unimplemented; software keeps the select at zero
  wire normal_op  = !fmt_opt[`FO_SCMODE];                                // [R7] [R8]
  wire deselect   = ext_a[`EA_SEL_EN] && sync_mode && select_input_pin_i; // [R9] [R11]
  wire [2:0] last_bit = eight_bits ? `LAST_BIT_8 : `LAST_BIT_7;

  // ****************************************
  // synchronous clock edge detect
  // ****************************************
  wire eff_sclk = deselect ? 1'b1 : serial_clock_pin_i;                  // [R10] [R12]
  reg  sclk_q;
  wire sclk_rise = eff_sclk && !sclk_q;
  wire sclk_fall = !eff_sclk && sclk_q;

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= eff_sclk;
    end
  end

  // ****************************************
  // transmit
  // ****************************************
  reg  [2:0]       tx_state;
  reg  [2:0]       tx_cnt;
  reg  [DIV_W-1:0] tx_tick_cnt;
  reg              tx_par;
  wire [7:0]       tx_line = flip ? ~tx_hold : tx_hold;                  // [R5]
  wire [7:0]       tx_line_m = eight_bits ? tx_line : {1'b0, tx_line[6:0]};
  wire             tx_load = normal_op && ser_fmt[`SF_TXEN] && !tx_empty && (tx_state == S_IDLE);
  wire             tx_tick = (tx_tick_cnt == {DIV_W{1'b0}});
  // sync: move on just after the peer's sampling edge, so bit 0 is seen first
  wire             tx_step = sync_mode ? sclk_rise : tx_tick;
  wire             tx_bit;
  reg              tx_shift;

  tx_bit_shifter #(
    .WIDTH (8)
  ) u_tx_shift (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .load_i  (tx_load),
    .data_i  (msb_first ? reverse8(tx_line_m) : tx_line_m),              // [R3]
    .shift_i (tx_shift),
    .bit_o   (tx_bit)
  );

  always @* begin
    tx_shift = 1'b0;
    if (tx_state == S_DATA && tx_step && tx_cnt != last_bit) begin
      tx_shift = 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      tx_state    <= S_IDLE;
      tx_cnt      <= 3'h0;
      tx_tick_cnt <= {DIV_W{1'b0}};
      tx_par      <= 1'b0;
    end else begin
      if (tx_load || tx_tick) begin
        tx_tick_cnt <= divisor;
      end else begin
        tx_tick_cnt <= tx_tick_cnt - 1'b1;
      end
      case (tx_state)
        S_IDLE: begin
          if (tx_load) begin
            tx_cnt   <= 3'h0;
            // parity over the line bits, never inverted itself
            tx_par   <= (^tx_line_m) ^ ser_fmt[`SF_ODD];                 // [R6]
            tx_state <= sync_mode ? S_DATA : S_START;
          end
        end
        S_START: begin
          if (tx_step) begin
            tx_state <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_step) begin
            if (tx_cnt == last_bit) begin
              if (sync_mode) begin
                tx_state <= S_IDLE;
              end else begin
                tx_state <= ser_fmt[`SF_PEN] ? S_PAR : S_STOP;
              end
            end else begin
              tx_cnt <= tx_cnt + 1'b1;
            end
          end
        end
        S_PAR: begin
          if (tx_step) begin
            tx_state <= S_STOP;
          end
        end
        S_STOP: begin
          if (tx_step) begin
            tx_state <= S_IDLE;
          end
        end
        default: begin
          tx_state <= S_IDLE;
        end
      endcase
    end
  end

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      transmit_data_out_o <= 1'b1;
      transmit_data_oe_o  <= 1'b1;
    end else begin
      transmit_data_oe_o <= !deselect;                                   // [R10] [R12]
      case (tx_state)
        S_START: transmit_data_out_o <= 1'b0;
        S_DATA:  transmit_data_out_o <= tx_bit;
        S_PAR:   transmit_data_out_o <= tx_par;
        default: transmit_data_out_o <= 1'b1;
      endcase
    end
  end

  // ****************************************
  // receive
  // ****************************************
  reg  [2:0]       rx_state;
  reg  [2:0]       rx_cnt;
  reg  [DIV_W-1:0] rx_tick_cnt;
  reg  [7:0]       rx_sr;
  reg              rx_in_q;
  reg              rx_done;
  reg              rx_bad;
  wire             rx_tick = (rx_tick_cnt == {DIV_W{1'b0}});
  wire             rx_samp = sync_mode ? sclk_rise : rx_tick;
  wire             rx_go   = normal_op && ser_fmt[`SF_RXEN] && !par_err;
  wire [7:0]       rx_line = eight_bits ? rx_sr : {1'b0, rx_sr[7:1]};
  wire [7:0]       rx_ord  = msb_first ? reverse8(rx_line) : rx_line;    // [R3] [R4]
  wire [7:0]       rx_store = flip ? (eight_bits ? ~rx_ord : {1'b0, ~rx_ord[6:0]}) : rx_ord; // [R5]

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      rx_state    <= S_IDLE;
      rx_cnt      <= 3'h0;
      rx_tick_cnt <= {DIV_W{1'b0}};
      rx_sr       <= 8'h00;
      rx_in_q     <= 1'b1;
      rx_done     <= 1'b0;
      rx_bad      <= 1'b0;
    end else begin
      rx_in_q <= receive_data_in_i;
      rx_done <= 1'b0;
      rx_bad  <= 1'b0;
      if (rx_tick) begin
        rx_tick_cnt <= divisor;
      end else begin
        rx_tick_cnt <= rx_tick_cnt - 1'b1;
      end
      case (rx_state)
        S_IDLE: begin
          rx_cnt <= 3'h0;
          if (rx_go && sync_mode) begin
            rx_state <= S_DATA;
          end else if (rx_go && rx_in_q && !receive_data_in_i) begin
            // land sampling near mid-bit
            rx_tick_cnt <= {1'b0, divisor[DIV_W-1:1]};
            rx_state    <= S_START;
          end
        end
        S_START: begin
          if (rx_tick) begin
            rx_state <= receive_data_in_i ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (!rx_go) begin
            rx_state <= S_IDLE;
          end else if (rx_samp) begin
            rx_sr <= {receive_data_in_i, rx_sr[7:1]};
            if (rx_cnt == last_bit) begin
              if (sync_mode) begin
                rx_done  <= 1'b1;
                rx_state <= S_IDLE;
              end else begin
                rx_state <= ser_fmt[`SF_PEN] ? S_PAR : S_STOP;
              end
            end else begin
              rx_cnt <= rx_cnt + 1'b1;
            end
          end
        end
        S_PAR: begin
          if (rx_tick) begin
            // checked on line bits, independent of inversion
            rx_bad   <= (^rx_line) ^ ser_fmt[`SF_ODD] ^ receive_data_in_i; // [R6]
            rx_state <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_tick) begin
            rx_done  <= 1'b1;
            rx_state <= S_IDLE;
          end
        end
        default: begin
          rx_state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // apb register file
  // ****************************************
  reg [31:0] rd_mux;
  reg        rd_err;

  always @* begin
    rd_err = 1'b0;
    case (paddr_i)
      `ADDR_FMT_OPT: rd_mux = {24'h000000, fmt_opt | `FO_RSV_ONES};     // [R1] [R2]
      `ADDR_EXT_A:   rd_mux = {24'h000000, ext_a};
      `ADDR_SER_FMT: rd_mux = {24'h000000, ser_fmt};
      `ADDR_DIV:     rd_mux = {{(32-DIV_W){1'b0}}, divisor};
      `ADDR_TXH:     rd_mux = {24'h000000, tx_hold};
      `ADDR_RXH:     rd_mux = {24'h000000, rx_hold};
      `ADDR_STAT:    rd_mux = {28'h0000000, par_err, (tx_state != S_IDLE), rx_full, tx_empty};
      default: begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      // one wait state: answer registered a cycle into the access phase
      pready_o  <= apb_access && !pready_o;
      pslverr_o <= apb_access && !pready_o && rd_err;
      prdata_o  <= (apb_access && !pready_o && !pwrite_i) ? rd_mux : 32'h00000000;
    end
  end

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      fmt_opt      <= `FO_RESET;
      ext_a        <= `EA_RESET;
      ser_fmt      <= `SF_RESET;
      divisor      <= `DIV_RESET;
      tx_hold      <= 8'h00;
      rx_hold      <= 8'h00;
      tx_empty     <= 1'b1;
      rx_full      <= 1'b0;
      par_err      <= 1'b0;
    end else begin
      if (apb_write) begin
        case (paddr_i)
          `ADDR_FMT_OPT: fmt_opt <= pwdata_i[7:0] | `FO_RSV_ONES;          // [R1] [R2]
          `ADDR_EXT_A:   ext_a   <= pwdata_i[7:0];
          `ADDR_SER_FMT: ser_fmt <= pwdata_i[7:0];
          `ADDR_DIV:     divisor <= pwdata_i[DIV_W-1:0];
          `ADDR_TXH:     tx_hold <= pwdata_i[7:0];
          default: begin
          end
        endcase
      end
      // set wins over clear on every status flag
      if (tx_load) begin
        tx_empty <= 1'b1;
      end else if (apb_write && paddr_i == `ADDR_TXH) begin
        tx_empty <= 1'b0;
      end
      if (rx_done) begin
        // a character with bad parity still lands, it is just not marked
        rx_hold <= rx_store;
      end
      if (rx_done && !par_err) begin
        rx_full <= 1'b1;
      end else if (apb_read && paddr_i == `ADDR_RXH) begin
        rx_full <= 1'b0;
      end
      if (rx_bad) begin
        par_err <= 1'b1;
      end else if (apb_write && paddr_i == `ADDR_STAT && pwdata_i[`ST_PERR]) begin
        par_err <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: bench/serial_fmt_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_consts.vh"

module serial_fmt_checker (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        select_input_pin_i,
  input wire logic        transmit_data_oe_o
);
  logic       sel_en;
  logic       sync;
  logic [3:0] fmt;
  wire        wr_done = pready_o && pwrite_i && !pslverr_o;
  wire        fmt_rd  = pready_o && !pwrite_i && paddr_i == `ADDR_FMT_OPT;

  // shadows follow completed writes, so no decode inside the design is trusted
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      sel_en <= 1'b0;
      sync <= 1'b0;
      fmt <= 4'h0;
    end else if (wr_done) begin
      if (paddr_i == `ADDR_EXT_A) sel_en <= pwdata_i[`EA_SEL_EN];
      if (paddr_i == `ADDR_SER_FMT) sync <= pwdata_i[`SF_SYNC];
      if (paddr_i == `ADDR_FMT_OPT) fmt <= pwdata_i[3:0];
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  pready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  ready_wait_a: assert property (psel_i && !penable_i ##1 psel_i && penable_i |=> pready_o)
    else $error("no answer one cycle after access");
  unmapped_err_a: assert property (pready_o |-> pslverr_o == (paddr_i > `ADDR_STAT))
    else $error("error response wrong for address");
  fmt_reserved_a: assert property (fmt_rd |-> prdata_o[7:4] == 4'hf && prdata_o[1])
    else $error("reserved format bits not read as ones");
  fmt_fields_a: assert property (fmt_rd |-> prdata_o[3:0] == {fmt[3:2], 1'b1, fmt[0]})
    else $error("format fields lost");
  select_float_a: assert property (sel_en && sync && select_input_pin_i |=> !transmit_data_oe_o)
    else $error("transmit output not floated");
  select_off_a: assert property (!sel_en |=> transmit_data_oe_o)
    else $error("floated with select disabled");
  async_drive_a: assert property (!sync |=> transmit_data_oe_o)
    else $error("floated in asynchronous mode");
  pin_low_a: assert property (!select_input_pin_i |=> transmit_data_oe_o)
    else $error("drive not restored with pin low");

  cover property (sel_en && sync && select_input_pin_i);
  cover property (pready_o && pslverr_o);
  cover property (pready_o && !pwrite_i && paddr_i == `ADDR_RXH);
endmodule

bind serial_format_and_select_control serial_fmt_checker i_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .select_input_pin_i(select_input_pin_i),
  .transmit_data_oe_o(transmit_data_oe_o)
);

`default_nettype wire

// file: bench/serial_peer_model.sv
`timescale 1ns/100ps
`default_nettype none

module serial_peer_model (
  input  wire logic clock_i,
  input  wire logic txd_i,
  output var  logic rxd_o,
  output var  logic sclk_o
);
  // clock stands high and line idles high outside frames
  initial begin
    rxd_o = 1'b1;
    sclk_o = 1'b1;
  end

  task automatic send(input logic [7:0] line, input int nb, input logic pe,
                      input logic par, input int bt);
    for (int k = -1; k <= nb + 1; k++) begin
      @(posedge clock_i);
      rxd_o <= (k < 0) ? 1'b0 : (k < nb) ? line[k] : (k == nb && pe) ? par : 1'b1;
      repeat (bt - 1) @(posedge clock_i);
    end
  endtask

  // bounded hunt for the start bit, then mid-bit sampling
  task automatic recv(output logic [7:0] line, output logic par, input int nb, input int bt);
    int n;
    line = 8'h00;
    par = 1'b1;
    n = 0;
    while (txd_i !== 1'b0 && n < 500) begin
      @(posedge clock_i);
      n++;
    end
    repeat (bt / 2) @(posedge clock_i);
    for (int k = 0; k <= nb; k++) begin
      repeat (bt) @(posedge clock_i);
      if (k < nb) line[k] = txd_i;
      else par = txd_i;
    end
    repeat (bt) @(posedge clock_i);
  endtask

  task automatic sync_clk(output logic [7:0] got, input int half);
    for (int k = 0; k < 8; k++) begin
      @(posedge clock_i);
      sclk_o <= 1'b0;
      repeat (half) @(posedge clock_i);
      got[k] = txd_i;
      sclk_o <= 1'b1;
      repeat (half) @(posedge clock_i);
    end
  endtask
endmodule

`default_nettype wire

// file: bench/serial_format_and_select_control_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_consts.vh"

module serial_format_and_select_control_test;
  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] sf;
    logic [7:0] line;
    logic [3:0] nb;
    logic       par;
  } row_t;

  logic        clock;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        sel_pin;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  got;
  logic        gpar;
  int          n_fail = 0;
  int          n_compared = 0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         tx_out;
  wire         tx_oe;
  wire         rxd;
  wire         sclk;
  // released pin rests on its pull-up
  wire         txd_line = tx_oe ? tx_out : 1'b1;

  // data 8'h35 in every row; line holds bits in wire order
  row_t rows [6] = '{
    '{8'h00, 8'h03, 8'h35, 4'd8, 1'b0},
    '{8'h08, 8'h03, 8'hac, 4'd8, 1'b0},
    '{8'h04, 8'h03, 8'hca, 4'd8, 1'b0},
    '{8'h0c, 8'h33, 8'h53, 4'd8, 1'b1},
    '{8'h08, 8'h43, 8'h35, 4'd7, 1'b0},
    '{8'h04, 8'h63, 8'h4a, 4'd7, 1'b1}
  };

  serial_format_and_select_control i_dut (
    .clock_i(clock), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .serial_clock_pin_i(sclk), .receive_data_in_i(rxd),
    .select_input_pin_i(sel_pin), .transmit_data_out_o(tx_out), .transmit_data_oe_o(tx_oe)
  );
  serial_peer_model i_peer (.clock_i(clock), .txd_i(txd_line), .rxd_o(rxd), .sclk_o(sclk));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic seen);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task results;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sel_pin = 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, `ADDR_FMT_OPT, 32'h0);
    chk("format reset", 32'hf2, rd);
    apb(1'b0, `ADDR_EXT_A, 32'h0);
    chk("ext reset", 32'h0, rd);
    apb(1'b1, `ADDR_FMT_OPT, 32'h0c);
    apb(1'b0, `ADDR_FMT_OPT, 32'h0);
    chk("format written", 32'hfe, rd);
    // smartcard select is never set
    apb(1'b1, `ADDR_FMT_OPT, 32'h0);
    apb(1'b0, `ADDR_FMT_OPT, 32'h0);
    chk("format cleared", 32'hf2, rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk_bit("unmapped error", 1'b1, er);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, `ADDR_DIV, 32'h3);
    foreach (rows[i]) begin
      apb(1'b1, `ADDR_FMT_OPT, {24'h0, rows[i].fmt});
      apb(1'b1, `ADDR_SER_FMT, {24'h0, rows[i].sf});
      apb(1'b1, `ADDR_TXH, 32'h35);
      i_peer.recv(got, gpar, rows[i].nb, 4);
      chk("tx line", {24'h0, rows[i].line}, {24'h0, got});
      if (rows[i].sf[`SF_PEN]) chk_bit("tx parity", rows[i].par, gpar);
      i_peer.send(rows[i].line, rows[i].nb, rows[i].sf[`SF_PEN], rows[i].par, 4);
      repeat (4) @(posedge clock);
      apb(1'b0, `ADDR_RXH, 32'h0);
      chk("rx data", 32'h35, rd);
    end
    apb(1'b1, `ADDR_FMT_OPT, 32'h0);
    apb(1'b1, `ADDR_SER_FMT, 32'h81);
    sel_pin <= 1'b1;
    repeat (3) @(posedge clock);
    chk_bit("oe select off", 1'b1, tx_oe);
    apb(1'b1, `ADDR_EXT_A, 32'h80);
    repeat (2) @(posedge clock);
    chk_bit("oe floated", 1'b0, tx_oe);
    apb(1'b1, `ADDR_TXH, 32'h34);
    // these pulses must not move the shifter while the clock is held high
    i_peer.sync_clk(got, 8);
    chk("floated line", 32'hff, {24'h0, got});
    sel_pin <= 1'b0;
    repeat (2) @(posedge clock);
    chk_bit("oe restored", 1'b1, tx_oe);
    i_peer.sync_clk(got, 8);
    chk("sync data", 32'h34, {24'h0, got});
    apb(1'b1, `ADDR_SER_FMT, 32'h03);
    sel_pin <= 1'b1;
    repeat (3) @(posedge clock);
    chk_bit("oe async", 1'b1, tx_oe);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, `ADDR_EXT_A, 32'h0);
    chk("ext after reset", 32'h0, rd);
    results;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    results;
  end
endmodule

`default_nettype wire
